// ---- rtl/bmrs_top.sv ----
// boot mode select, reset entry and test port control
//
// Summary of operation
// - eprom strap high with link strap low selects byte-wide eprom boot; both high is reserved; else other straps decide.
// - with eprom strap low, link strap high selects link boot if select input is high; low selects host or no boot.
// - eprom=1, link=0 drives boot memory select as eprom chip select.
// - with several processors only the bus owner drives boot memory select.
// - both straps low and select input low: no boot, fetch externally.
// - straps 0,0 with select input 1 select host boot.
// - straps 0,1 with select input 1 select link boot.
// - select pin is driven only in eprom mode; otherwise plain input.
// - one instruction per core clock period.
// - reset gives a known state then starts at the reset vector.
// - scan logic runs on core clock; test clock is sampled and must run well below it.
// - test mode select steers the state machine; data in, scan out.
// - test reset low resets test state machine; pulsed or held low.
`timescale 1ns/1ns
`default_nettype none
module bmrs_top (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // straps
  input wire logic EPROM_BOOT_STRAP_I,
  input wire logic LINK_BOOT_STRAP_I,
  // boot memory select pin
  input wire logic BOOT_MEM_SEL_I,
  output logic BOOT_MEM_SEL_O,
  output logic BOOT_MEM_SEL_OE_O,
  // loader side
  input wire logic BUS_MASTER_I,
  input wire logic EPROM_CS_REQ_I,
  // boot status
  output bmrs_pkg::bmrs_mode_t BOOT_MODE_O,
  output logic BOOT_RESERVED_O,
  output logic FETCH_START_O,
  output logic INSTR_TICK_O,
  output logic [bmrs_pkg::ADDR_W-1:0] FETCH_ADDR_O,
  // test port
  input wire logic TCK_I,
  input wire logic TMS_I,
  input wire logic TDI_I,
  input wire logic TRST_N_I,
  output logic TDO_O,
  output logic EMULATION_STATUS_N_O,
  output logic EMULATION_STATUS_N_OE_O,
  output logic RESERVED_OUTPUT_PIN_O
);

  // ==========================================================
  // boot mode decode and latch
  // ==========================================================
  bmrs_pkg::bmrs_strap_t straps;
  bmrs_pkg::bmrs_boot_t state, next_state;
  bmrs_pkg::bmrs_mode_t mode, next_mode, decoded;
  logic [bmrs_pkg::ADDR_W-1:0] pc, next_pc;
  logic start, next_start;

  assign straps = '{eprom_boot_strap: EPROM_BOOT_STRAP_I,
                    link_boot_strap: LINK_BOOT_STRAP_I,
                    boot_memory_select: BOOT_MEM_SEL_I};

  always_comb begin
    decoded = bmrs_pkg::MODE_RSVD;
    if (straps.eprom_boot_strap) begin
      if (!straps.link_boot_strap) begin
        decoded = bmrs_pkg::MODE_EPROM;
      end
    end else if (straps.link_boot_strap) begin
      if (straps.boot_memory_select) begin
        decoded = bmrs_pkg::MODE_LINK;
      end
    end else if (straps.boot_memory_select) begin
      decoded = bmrs_pkg::MODE_HOST;
    end else begin
      decoded = bmrs_pkg::MODE_NONE;
    end
  end

  // straps are caught on the first edge after release; an async
  // reset flop may only take a constant
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_pc = pc;
    next_start = 1'b0;
    unique case (state)
      bmrs_pkg::ST_LATCH: begin
        next_mode = decoded;
        next_state = bmrs_pkg::ST_START;
      end
      bmrs_pkg::ST_START: begin
        next_start = 1'b1;
        next_pc = bmrs_pkg::RESET_VECTOR;
        next_state = bmrs_pkg::ST_RUN;
      end
      bmrs_pkg::ST_RUN: begin
        next_pc = pc + bmrs_pkg::ADDR_STEP;
      end
      default: begin
        next_state = bmrs_pkg::ST_LATCH;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state <= bmrs_pkg::ST_LATCH;
      mode <= bmrs_pkg::MODE_NONE;
      pc <= bmrs_pkg::RESET_VECTOR;
      start <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      pc <= next_pc;
      start <= next_start;
    end
  end

  assign BOOT_MODE_O = mode;
  assign BOOT_RESERVED_O = (mode == bmrs_pkg::MODE_RSVD);
  assign FETCH_START_O = start;
  assign FETCH_ADDR_O = pc;
  assign INSTR_TICK_O = (state == bmrs_pkg::ST_RUN);

  // pin is driven only in eprom mode and only by the bus owner;
  // chip select is active low
  assign BOOT_MEM_SEL_OE_O = (mode == bmrs_pkg::MODE_EPROM) &&
                             (state != bmrs_pkg::ST_LATCH) &&
                             BUS_MASTER_I;
  assign BOOT_MEM_SEL_O = ~EPROM_CS_REQ_I;

  // ==========================================================
  // test port synchroniser
  // ==========================================================
  // test clock is sampled, so it must run well below the core clock
  bmrs_pkg::bmrs_jtag_t jt_meta, jt_sync, next_jt_meta, next_jt_sync;
  logic tck_d, next_tck_d;
  logic tck_rise, tck_fall;

  always_comb begin
    next_jt_meta = '{trst_n: TRST_N_I, tdi: TDI_I, tms: TMS_I,
                     tck: TCK_I};
    next_jt_sync = jt_meta;
    next_tck_d = jt_sync.tck;
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      jt_meta <= '{trst_n: 1'b0, tdi: 1'b1, tms: 1'b1, tck: 1'b1};
      jt_sync <= '{trst_n: 1'b0, tdi: 1'b1, tms: 1'b1, tck: 1'b1};
      tck_d <= 1'b1; // test clock idles high: no false edge after reset
    end else begin
      jt_meta <= next_jt_meta;
      jt_sync <= next_jt_sync;
      tck_d <= next_tck_d;
    end
  end

  assign tck_rise = jt_sync.tck && !tck_d;
  assign tck_fall = !jt_sync.tck && tck_d;

  // ==========================================================
  // test state machine and scan registers
  // ==========================================================
  bmrs_pkg::bmrs_tap_t tap, next_tap, tap_step;
  logic [bmrs_pkg::IR_W-1:0] ir, next_ir, ir_sh, next_ir_sh;
  logic [bmrs_pkg::BSR_W-1:0] bsr, next_bsr;
  logic byp, next_byp, tdo, next_tdo;
  logic tms;

  assign tms = jt_sync.tms;

  always_comb begin
    tap_step = tap;
    unique case (tap)
      bmrs_pkg::TAP_TLR:
        tap_step = tms ? bmrs_pkg::TAP_TLR : bmrs_pkg::TAP_IDLE;
      bmrs_pkg::TAP_IDLE:
        tap_step = tms ? bmrs_pkg::TAP_SELDR : bmrs_pkg::TAP_IDLE;
      bmrs_pkg::TAP_SELDR:
        tap_step = tms ? bmrs_pkg::TAP_SELIR : bmrs_pkg::TAP_CAPDR;
      bmrs_pkg::TAP_CAPDR:
        tap_step = tms ? bmrs_pkg::TAP_EX1DR : bmrs_pkg::TAP_SHDR;
      bmrs_pkg::TAP_SHDR:
        tap_step = tms ? bmrs_pkg::TAP_EX1DR : bmrs_pkg::TAP_SHDR;
      bmrs_pkg::TAP_EX1DR:
        tap_step = tms ? bmrs_pkg::TAP_UPDR : bmrs_pkg::TAP_PAUDR;
      bmrs_pkg::TAP_PAUDR:
        tap_step = tms ? bmrs_pkg::TAP_EX2DR : bmrs_pkg::TAP_PAUDR;
      bmrs_pkg::TAP_EX2DR:
        tap_step = tms ? bmrs_pkg::TAP_UPDR : bmrs_pkg::TAP_SHDR;
      bmrs_pkg::TAP_UPDR:
        tap_step = tms ? bmrs_pkg::TAP_SELDR : bmrs_pkg::TAP_IDLE;
      bmrs_pkg::TAP_SELIR:
        tap_step = tms ? bmrs_pkg::TAP_TLR : bmrs_pkg::TAP_CAPIR;
      bmrs_pkg::TAP_CAPIR:
        tap_step = tms ? bmrs_pkg::TAP_EX1IR : bmrs_pkg::TAP_SHIR;
      bmrs_pkg::TAP_SHIR:
        tap_step = tms ? bmrs_pkg::TAP_EX1IR : bmrs_pkg::TAP_SHIR;
      bmrs_pkg::TAP_EX1IR:
        tap_step = tms ? bmrs_pkg::TAP_UPIR : bmrs_pkg::TAP_PAUIR;
      bmrs_pkg::TAP_PAUIR:
        tap_step = tms ? bmrs_pkg::TAP_EX2IR : bmrs_pkg::TAP_PAUIR;
      bmrs_pkg::TAP_EX2IR:
        tap_step = tms ? bmrs_pkg::TAP_UPIR : bmrs_pkg::TAP_SHIR;
      bmrs_pkg::TAP_UPIR:
        tap_step = tms ? bmrs_pkg::TAP_SELDR : bmrs_pkg::TAP_IDLE;
    endcase
  end

  always_comb begin
    next_tap = tap;
    next_ir = ir;
    next_ir_sh = ir_sh;
    next_bsr = bsr;
    next_byp = byp;
    next_tdo = tdo;
    if (!jt_sync.trst_n) begin
      next_tap = bmrs_pkg::TAP_TLR;
      next_ir = bmrs_pkg::IR_BYPASS;
    end else if (tck_rise) begin
      next_tap = tap_step;
      unique case (tap)
        bmrs_pkg::TAP_TLR: next_ir = bmrs_pkg::IR_BYPASS;
        bmrs_pkg::TAP_CAPIR: next_ir_sh = bmrs_pkg::IR_CAPTURE;
        bmrs_pkg::TAP_SHIR:
          next_ir_sh = {jt_sync.tdi, ir_sh[bmrs_pkg::IR_W-1:1]};
        bmrs_pkg::TAP_UPIR: next_ir = ir_sh;
        bmrs_pkg::TAP_CAPDR: begin
          next_bsr = straps; // boundary sample of the strap pins
          next_byp = 1'b0;
        end
        bmrs_pkg::TAP_SHDR: begin
          next_bsr = {jt_sync.tdi, bsr[bmrs_pkg::BSR_W-1:1]};
          next_byp = jt_sync.tdi;
        end
        default: begin
          next_ir = ir;
        end
      endcase
    end else if (tck_fall) begin
      // scan out changes on the falling test clock
      if (tap == bmrs_pkg::TAP_SHIR) begin
        next_tdo = ir_sh[0];
      end else if (tap == bmrs_pkg::TAP_SHDR) begin
        next_tdo = (ir == bmrs_pkg::IR_BYPASS) ? byp : bsr[0];
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tap <= bmrs_pkg::TAP_TLR;
      ir <= bmrs_pkg::IR_BYPASS;
      ir_sh <= '0;
      bsr <= '0;
      byp <= 1'b0;
      tdo <= 1'b0;
    end else begin
      tap <= next_tap;
      ir <= next_ir;
      ir_sh <= next_ir_sh;
      bsr <= next_bsr;
      byp <= next_byp;
      tdo <= next_tdo;
    end
  end

  assign TDO_O = tdo;
  // open drain, pulled low while emulation is selected
  assign EMULATION_STATUS_N_O = 1'b0;
  assign EMULATION_STATUS_N_OE_O = (ir == bmrs_pkg::IR_EMUL);
  assign RESERVED_OUTPUT_PIN_O = 1'b0;

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  a_sel_drive_gate: assert property (
    BOOT_MEM_SEL_OE_O |-> mode == bmrs_pkg::MODE_EPROM && BUS_MASTER_I)
    else $error("select pin driven outside eprom ownership");
  a_eprom_decode: assert property (
    state == bmrs_pkg::ST_LATCH && EPROM_BOOT_STRAP_I &&
    !LINK_BOOT_STRAP_I |=> mode == bmrs_pkg::MODE_EPROM &&
    (!BUS_MASTER_I || BOOT_MEM_SEL_OE_O))
    else $error("eprom straps not decoded");
  a_host_decode: assert property (
    state == bmrs_pkg::ST_LATCH && straps == 3'b001
    |=> mode == bmrs_pkg::MODE_HOST)
    else $error("host straps not decoded");
  a_link_decode: assert property (
    state == bmrs_pkg::ST_LATCH && straps == 3'b011
    |=> mode == bmrs_pkg::MODE_LINK)
    else $error("link straps not decoded");
  a_noboot_decode: assert property (
    state == bmrs_pkg::ST_LATCH && straps == 3'b000
    |=> mode == bmrs_pkg::MODE_NONE)
    else $error("no boot straps not decoded");
  a_mode_frozen: assert property (
    state == bmrs_pkg::ST_RUN |=> $stable(mode))
    else $error("boot mode changed after latch");
  a_vector_start: assert property (
    $rose(RESETN_I) |-> ##2 start && INSTR_TICK_O &&
    FETCH_ADDR_O == bmrs_pkg::RESET_VECTOR ##1 !start)
    else $error("start not at reset vector");
  a_instr_rate: assert property (
    INSTR_TICK_O |=> INSTR_TICK_O &&
    FETCH_ADDR_O == $past(FETCH_ADDR_O) + bmrs_pkg::ADDR_STEP)
    else $error("instruction rate not one per clock");
  a_trst_reset: assert property (
    !jt_sync.trst_n |=> tap == bmrs_pkg::TAP_TLR)
    else $error("test reset ignored");
  a_tck_steps: assert property (
    jt_sync.trst_n && !tck_rise |=> $stable(tap))
    else $error("test state moved without test clock");
  a_tms_idle: assert property (
    jt_sync.trst_n && tck_rise && tap == bmrs_pkg::TAP_TLR && !tms
    |=> tap == bmrs_pkg::TAP_IDLE)
    else $error("mode select did not leave reset state");

  c_eprom_run: cover property (
    mode == bmrs_pkg::MODE_EPROM && BOOT_MEM_SEL_OE_O);
  c_link_run: cover property (
    mode == bmrs_pkg::MODE_LINK && INSTR_TICK_O);
  c_noboot_run: cover property (
    mode == bmrs_pkg::MODE_NONE && INSTR_TICK_O);
  c_shift_dr: cover property (tap == bmrs_pkg::TAP_SHDR && tck_fall);

endmodule // bmrs_top
`default_nettype wire

// ---- rtl/bmrs_pkg.sv ----
// package: constants and types of the boot mode and reset select block
package bmrs_pkg;
  // boot modes after decode
  typedef enum logic [2:0] {
    MODE_NONE  = 3'b000,
    MODE_HOST  = 3'b001,
    MODE_LINK  = 3'b010,
    MODE_EPROM = 3'b011,
    MODE_RSVD  = 3'b100
  } bmrs_mode_t;

  // boot sequencing
  typedef enum logic [1:0] {
    ST_LATCH = 2'b00,
    ST_START = 2'b01,
    ST_RUN   = 2'b10
  } bmrs_boot_t;

  // test state machine
  typedef enum logic [3:0] {
    TAP_TLR = 4'h0, TAP_IDLE = 4'h1, TAP_SELDR = 4'h2, TAP_CAPDR = 4'h3,
    TAP_SHDR = 4'h4, TAP_EX1DR = 4'h5, TAP_PAUDR = 4'h6, TAP_EX2DR = 4'h7,
    TAP_UPDR = 4'h8, TAP_SELIR = 4'h9, TAP_CAPIR = 4'hA, TAP_SHIR = 4'hB,
    TAP_EX1IR = 4'hC, TAP_PAUIR = 4'hD, TAP_EX2IR = 4'hE, TAP_UPIR = 4'hF
  } bmrs_tap_t;

  typedef struct packed {
    logic eprom_boot_strap;
    logic link_boot_strap;
    logic boot_memory_select;
  } bmrs_strap_t;

  typedef struct packed {
    logic trst_n;
    logic tdi;
    logic tms;
    logic tck;
  } bmrs_jtag_t;

  localparam int ADDR_W = 24;
  // reset vector value is a plain default
  localparam logic [ADDR_W-1:0] RESET_VECTOR = 24'h000000;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 24'h000001;
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_SAMPLE = 4'h0;
  localparam logic [IR_W-1:0] IR_EMUL = 4'h1;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam int BSR_W = 3;
endpackage

// ---- verification/bmrs_board.sv ----
// board model: straps, pin pull-ups and test controller
`timescale 1ns/1ns
`default_nettype none
module bmrs_board (
  // clock
  input wire logic clk_i,
  // strap setting and device pins
  input wire bmrs_pkg::bmrs_strap_t strap_i,
  input wire logic sel_o_i,
  input wire logic sel_oe_i,
  input wire logic stat_o_i,
  input wire logic stat_oe_i,
  input wire logic tdo_i,
  // board side of the pins
  output logic eprom_strap_o,
  output logic link_strap_o,
  output logic sel_pin_o,
  output logic stat_pin_o,
  output var bmrs_pkg::bmrs_jtag_t jtag_o
);
  // ====
  // pins
  assign eprom_strap_o = strap_i.eprom_boot_strap;
  assign link_strap_o = strap_i.link_boot_strap;
  // strap resistor wins only while the device is not driving
  assign sel_pin_o = sel_oe_i ? sel_o_i : strap_i.boot_memory_select;
  // open drain, goes to the emulator connector only
  assign stat_pin_o = stat_oe_i ? stat_o_i : 1'h1;

  // ====
  // test controller
  initial begin
    jtag_o = 4'h6;
  end

  task automatic trst_pulse();
    @(posedge clk_i);
    jtag_o.trst_n <= 1'h0;
    repeat (8) @(posedge clk_i);
    jtag_o.trst_n <= 1'h1;
    repeat (4) @(posedge clk_i);
  endtask

  // phases of six core cycles, sync needs three
  task automatic scan(input logic [15:0] tms_v, input logic [15:0] tdi_v,
                      input int n, output logic [15:0] tdo_v);
    tdo_v = 16'h0000;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      jtag_o.tck <= 1'h0;
      jtag_o.tms <= tms_v[i];
      jtag_o.tdi <= tdi_v[i];
      repeat (6) @(posedge clk_i);
      tdo_v[i] = tdo_i;
      jtag_o.tck <= 1'h1;
      repeat (5) @(posedge clk_i);
    end
  endtask
endmodule // bmrs_board
`default_nettype wire

// ---- verification/bmrs_top_test.sv ----
// self-checking bench of the boot mode and reset select block
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, ex, got) \
  begin \
    checked++; \
    if ((got) !== (ex)) begin \
      n_mismatch++; \
      $display("Error %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module bmrs_top_test;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  bmrs_pkg::bmrs_strap_t strap = 3'h0;
  logic bus_master = 1'h0;
  logic cs_req = 1'h0;
  logic estrap, lstrap, sel_pin, sel_o, sel_oe, tdo, stat_o, stat_oe;
  logic stat_pin;
  logic fstart, tick, rsvd;
  logic [bmrs_pkg::ADDR_W-1:0] addr;
  logic [15:0] tdo_v;
  bmrs_pkg::bmrs_jtag_t jtag;
  bmrs_pkg::bmrs_mode_t mode;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;

  // ====
  // clock, design and board
  always #5 clk = ~clk;

  bmrs_top i_bmrs_top (
    .CLK_I(clk), .RESETN_I(resetn),
    .EPROM_BOOT_STRAP_I(estrap), .LINK_BOOT_STRAP_I(lstrap),
    .BOOT_MEM_SEL_I(sel_pin), .BOOT_MEM_SEL_O(sel_o),
    .BOOT_MEM_SEL_OE_O(sel_oe), .BUS_MASTER_I(bus_master),
    .EPROM_CS_REQ_I(cs_req), .BOOT_MODE_O(mode), .BOOT_RESERVED_O(rsvd),
    .FETCH_START_O(fstart), .INSTR_TICK_O(tick), .FETCH_ADDR_O(addr),
    .TCK_I(jtag.tck), .TMS_I(jtag.tms), .TDI_I(jtag.tdi),
    .TRST_N_I(jtag.trst_n), .TDO_O(tdo), .EMULATION_STATUS_N_O(stat_o),
    .EMULATION_STATUS_N_OE_O(stat_oe), .RESERVED_OUTPUT_PIN_O()
  );

  bmrs_board i_bmrs_board (
    .clk_i(clk), .strap_i(strap), .sel_o_i(sel_o), .sel_oe_i(sel_oe),
    .stat_o_i(stat_o), .stat_oe_i(stat_oe), .tdo_i(tdo),
    .eprom_strap_o(estrap), .link_strap_o(lstrap), .sel_pin_o(sel_pin),
    .stat_pin_o(stat_pin), .jtag_o(jtag)
  );

  // ====
  // helpers
  function automatic bmrs_pkg::bmrs_mode_t exp_mode(input logic [2:0] s);
    case (s)
      3'h4, 3'h5: return bmrs_pkg::MODE_EPROM;
      3'h1: return bmrs_pkg::MODE_HOST;
      3'h3: return bmrs_pkg::MODE_LINK;
      3'h0: return bmrs_pkg::MODE_NONE;
      default: return bmrs_pkg::MODE_RSVD;
    endcase
  endfunction

  task automatic stop_test();
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // one reset with the given straps, then the boot sequence
  task automatic boot(input logic [2:0] code);
    bmrs_pkg::bmrs_mode_t m;
    logic ep;
    m = exp_mode(code);
    ep = (m == bmrs_pkg::MODE_EPROM);
    @(posedge clk);
    resetn <= 1'h0;
    strap <= code;
    bus_master <= 1'h1;
    cs_req <= 1'h1;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    #1;
    `CHECK("mode", m, mode)
    `CHECK("reserved", (m == bmrs_pkg::MODE_RSVD), rsvd)
    @(posedge clk);
    #1;
    `CHECK("start", 1'h1, fstart)
    `CHECK("vector", bmrs_pkg::RESET_VECTOR, addr)
    @(posedge clk);
    #1;
    `CHECK("start end", 1'h0, fstart)
    `CHECK("tick", 1'h1, tick)
    repeat (5) @(posedge clk);
    #1;
    // vector stands with the start pulse, then one step per clock
    `CHECK("addr", bmrs_pkg::RESET_VECTOR + 24'h000006, addr)
    `CHECK("pin drive", ep, sel_oe)
    if (ep) `CHECK("chip select", 1'h0, sel_pin)
    @(posedge clk);
    bus_master <= 1'h0;
    cs_req <= 1'h0;
    #1;
    `CHECK("bus owner", 1'h0, sel_oe)
    if (ep) `CHECK("cs idle", 1'h1, sel_o)
    // straps moved on purpose after the latch
    @(posedge clk);
    strap <= ~code;
    repeat (2) @(posedge clk);
    #1;
    `CHECK("held", m, mode)
  endtask

  // ====
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'h1;
    // reserved codes included to see them refused
    for (int c = 0; c < 8; c++) begin
      boot(c[2:0]);
    end
    boot(3'h3);
    i_bmrs_board.trst_pulse();
    // load the emulation instruction
    i_bmrs_board.scan(16'h0306, 16'h0020, 11, tdo_v);
    `CHECK("status active", 1'h0, stat_pin)
    i_bmrs_board.trst_pulse();
    `CHECK("status reset", 1'h1, stat_pin)
    // sample instruction, then three data bits out
    i_bmrs_board.scan(16'h0306, 16'h0000, 11, tdo_v);
    i_bmrs_board.scan(16'h0061, 16'h0000, 8, tdo_v);
    // pins were left at the inverse of the last boot code
    `CHECK("scan out", 3'h4, tdo_v[5:3])
    stop_test();
  end
endmodule // bmrs_top_test
`default_nettype wire
